// file: rtl/schp_pkg.sv
// Shared types and constants for the storage card host port.
// Assumes a single 40 MHz clock domain with a synchronous reset.
`default_nettype none

package schp_pkg;

	localparam int ADDR_W = 11;
	localparam int DATA_W = 16;
	localparam int BYTE_W = 8;
	localparam int SYNC_STAGES = 2;

	// Task file register that carries the drive select bit
	localparam logic [2:0] TF_DEV_HEAD = 3'h6;
	localparam int DEV_BIT = 4;
	localparam int TF_SEL_W = 3;

	// Cycles after reset release before the role pin is trusted
	localparam logic [1:0] ROLE_CAP_CYCLES = 2'h2;

	// Byte lanes: bit 0 is D[7:0] (even byte), bit 1 is D[15:8] (odd)
	localparam logic [1:0] LANE_NONE = 2'h0;
	localparam logic [1:0] LANE_LO = 2'h1;
	localparam logic [1:0] LANE_HI = 2'h2;
	localparam logic [1:0] LANE_BOTH = 2'h3;

	typedef enum logic [1:0] {
		SCHP_MEMORY,
		SCHP_IO,
		SCHP_ATA
	} schp_mode_t;

	// Host driven pins, all strobes active low
	typedef struct packed {
		logic cs0_n;
		logic cs1_n;
		logic ce1_n;
		logic ce2_n;
		logic oe_n;
		logic we_n;
		logic iord_n;
		logic iowr_n;
		logic dmack_n;
		logic reg_n;
		logic [ADDR_W-1:0] addr;
	} schp_pins_t;

	localparam int PINS_W = $bits(schp_pins_t);
	localparam logic [PINS_W-1:0] PINS_IDLE = 21'h1FF800;

	// One access handed to the card core
	typedef struct packed {
		logic valid;
		logic write;
		logic taskfile;
		logic dma;
		logic [ADDR_W-1:0] addr;
		logic [1:0] lanes;
		logic [DATA_W-1:0] data;
	} schp_acc_t;

endpackage : schp_pkg

`default_nettype wire

// file: rtl/schp_sync.sv
// Two flip-flop synchroniser for a vector of pin inputs.
// Assumes every bit is an independent level from outside the clock domain.
`default_nettype none

module schp_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic mclk_i,
	input wire logic srst_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	// First stage feeds only the second stage
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			meta_q <= RST_VAL;
			sync_q <= RST_VAL;
		end else begin
			meta_q <= async_i;
			sync_q <= meta_q;
		end
	end

	assign sync_o = sync_q;

endmodule : schp_sync

`default_nettype wire

// file: rtl/schp_host_port.sv
// Host facing pin logic of a removable flash storage card.
// Assumes the card core supplies the mode, read data and DMA readiness.
`default_nettype none

module schp_host_port (
	input wire logic mclk_i,
	input wire logic srst_i,
	input wire schp_pkg::schp_mode_t mode_i,
	input wire schp_pkg::schp_pins_t pins_i,
	input wire logic drive_role_select_n_i,
	input wire logic [schp_pkg::DATA_W-1:0] data_i,
	input wire logic [schp_pkg::DATA_W-1:0] rd_data_i,
	input wire logic dma_pending_i,
	output schp_pkg::schp_acc_t acc_o,
	output logic [schp_pkg::DATA_W-1:0] data_o,
	output logic [1:0] data_oe_o,
	output logic io_read_acknowledge_n_o,
	output logic dmarq_o,
	output logic dmarq_oe_o,
	output logic role_slave_o
);
	import schp_pkg::*;

	localparam int SYNC_W = PINS_W + DATA_W + 1;

	typedef enum logic [1:0] {
		DMA_IDLE,
		DMA_REQ,
		DMA_ACKED
	} schp_dma_t;

	// Byte lanes for a card enable pair in memory and io modes
	function automatic logic [1:0] card_lanes(input logic ce1_n,
		input logic ce2_n, input logic a0);
		logic [1:0] l;
		l = LANE_NONE;
		if (!ce1_n && !ce2_n) begin
			l = LANE_BOTH;
		end else if (!ce2_n) begin
			l = LANE_HI;
		end else if (!ce1_n) begin
			l = LANE_LO;
		end
		return l;
	endfunction : card_lanes

	schp_pins_t p;
	logic [DATA_W-1:0] s_data;
	logic s_role_n;

	schp_sync #(
		.WIDTH(SYNC_W),
		.RST_VAL({PINS_IDLE, {DATA_W{1'b0}}, 1'b1})
	) u_sync (
		.mclk_i(mclk_i),
		.srst_i(srst_i),
		.async_i({pins_i, data_i, drive_role_select_n_i}),
		.sync_o({p, s_data, s_role_n})
	);

	logic ata;
	logic tf_sel;
	logic dma_cyc;
	logic card_sel;
	logic rd_act;
	logic wr_act;
	logic [1:0] lanes;

	// DMA cycles need no chip select
	always_comb begin
		ata = (mode_i == SCHP_ATA);
		dma_cyc = ata && !p.dmack_n;
		tf_sel = ata && p.dmack_n && (!p.cs0_n || !p.cs1_n);
		card_sel = !ata && (!p.ce1_n || !p.ce2_n);
		rd_act = 1'b0;
		wr_act = 1'b0;
		lanes = LANE_NONE;
		if (card_sel) begin
			lanes = card_lanes(p.ce1_n, p.ce2_n, p.addr[0]);
		end
		if (tf_sel) begin
			lanes = LANE_LO;
		end else if (dma_cyc) begin
			lanes = LANE_BOTH;
		end
		// io strobes unused in memory mode
		case (mode_i)
			SCHP_MEMORY: begin
				rd_act = card_sel && !p.oe_n;
				wr_act = card_sel && !p.we_n;
			end
			SCHP_IO: begin
				rd_act = card_sel && (!p.iord_n || !p.oe_n);
				wr_act = card_sel && (!p.iowr_n || !p.we_n);
			end
			SCHP_ATA: begin
				rd_act = (tf_sel || dma_cyc) && !p.iord_n;
				wr_act = (tf_sel || dma_cyc) && !p.iowr_n;
			end
			default: begin
				rd_act = 1'b0;
				wr_act = 1'b0;
			end
		endcase
	end

	// Access tracking
	logic rd_prev_q, rd_prev_d;
	logic wr_prev_q, wr_prev_d;
	schp_acc_t wr_info_q, wr_info_d;
	schp_acc_t acc_q, acc_d;
	logic [DATA_W-1:0] data_q, data_d;
	logic [1:0] data_oe_q, data_oe_d;
	logic ack_n_q, ack_n_d;
	logic dev_q, dev_d;

	always_comb begin
		rd_prev_d = rd_act;
		wr_prev_d = wr_act;
		wr_info_d = wr_info_q;
		acc_d = '0;
		dev_d = dev_q;
		// Write data is taken each strobe cycle, used at the trailing edge
		if (wr_act) begin
			wr_info_d.write = 1'b1;
			wr_info_d.taskfile = tf_sel;
			wr_info_d.dma = dma_cyc;
			wr_info_d.addr = tf_sel ?
				{{(ADDR_W-TF_SEL_W){1'b0}}, p.addr[TF_SEL_W-1:0]} : p.addr;
			wr_info_d.lanes = lanes;
			wr_info_d.data = s_data;
		end
		if (rd_act && !rd_prev_q) begin
			acc_d.valid = 1'b1;
			acc_d.taskfile = tf_sel;
			acc_d.dma = dma_cyc;
			acc_d.addr = tf_sel ?
				{{(ADDR_W-TF_SEL_W){1'b0}}, p.addr[TF_SEL_W-1:0]} : p.addr;
			acc_d.lanes = lanes;
		end else if (!wr_act && wr_prev_q) begin
			acc_d = wr_info_q;
			acc_d.valid = 1'b1;
			// Snoop the drive select bit of the device/head register
			if (wr_info_q.taskfile &&
				wr_info_q.addr[TF_SEL_W-1:0] == TF_DEV_HEAD) begin
				dev_d = wr_info_q.data[DEV_BIT];
			end
		end
		data_d = rd_data_i;
		data_oe_d = rd_act ? lanes : LANE_NONE;
		ack_n_d = !((mode_i == SCHP_IO) && rd_act && !p.iord_n);
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			rd_prev_q <= 1'b0;
			wr_prev_q <= 1'b0;
			wr_info_q <= '0;
			acc_q <= '0;
			data_q <= '0;
			data_oe_q <= LANE_NONE;
			ack_n_q <= 1'b1;
			dev_q <= 1'b0;
		end else begin
			rd_prev_q <= rd_prev_d;
			wr_prev_q <= wr_prev_d;
			wr_info_q <= wr_info_d;
			acc_q <= acc_d;
			data_q <= data_d;
			data_oe_q <= data_oe_d;
			ack_n_q <= ack_n_d;
			dev_q <= dev_d;
		end
	end

	// Role capture waits out the synchroniser so a reset value is never used
	logic [1:0] cap_cnt_q, cap_cnt_d;
	logic role_q, role_d;
	logic role_cap_q, role_cap_d;

	always_comb begin
		cap_cnt_d = cap_cnt_q;
		role_d = role_q;
		role_cap_d = role_cap_q;
		if (!role_cap_q) begin
			if (cap_cnt_q == ROLE_CAP_CYCLES) begin
				role_d = s_role_n;
				role_cap_d = 1'b1;
			end else begin
				cap_cnt_d = cap_cnt_q + 2'h1;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			cap_cnt_q <= 2'h0;
			role_q <= 1'b0;
			role_cap_q <= 1'b0;
		end else begin
			cap_cnt_q <= cap_cnt_d;
			role_q <= role_d;
			role_cap_q <= role_cap_d;
		end
	end

	// DMA request handshake
	logic selected;
	schp_dma_t dma_q, dma_d;
	logic dmarq_q, dmarq_d;
	logic dmarq_oe_q, dmarq_oe_d;

	always_comb begin
		selected = ata && role_cap_q && (dev_q == role_q);
		dma_d = dma_q;
		dmarq_oe_d = selected;
		case (dma_q)
			// no request while the core has nothing pending
			DMA_IDLE: begin
				if (selected && dma_pending_i) begin
					dma_d = DMA_REQ;
				end
			end
			DMA_REQ: begin
				if (!p.dmack_n) begin
					dma_d = DMA_ACKED;
				end
			end
			// request held while data remains, back to request on release if data remains
			DMA_ACKED: begin
				if (p.dmack_n) begin
					dma_d = dma_pending_i && selected ? DMA_REQ : DMA_IDLE;
				end
			end
			default: begin
				dma_d = DMA_IDLE;
			end
		endcase
		dmarq_d = (dma_d == DMA_REQ) ||
			((dma_d == DMA_ACKED) && dma_pending_i);
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			dma_q <= DMA_IDLE;
			dmarq_q <= 1'b0;
			dmarq_oe_q <= 1'b0;
		end else begin
			dma_q <= dma_d;
			dmarq_q <= dmarq_d;
			dmarq_oe_q <= dmarq_oe_d;
		end
	end

	assign acc_o = acc_q;
	assign data_o = data_q;
	assign data_oe_o = data_oe_q;
	assign io_read_acknowledge_n_o = ack_n_q;
	assign dmarq_o = dmarq_q;
	assign dmarq_oe_o = dmarq_oe_q;
	assign role_slave_o = role_q;

	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (srst_i);

	role_held_a: assert property (role_cap_q |=> $stable(role_q))
		else $error("drive role changed after capture");
	role_taken_a: assert property (
		!role_cap_q && cap_cnt_q == ROLE_CAP_CYCLES |=> role_q == $past(s_role_n))
		else $error("drive role not taken from pin");
	dmarq_hold_a: assert property (
		dmarq_q && dma_q == DMA_REQ && p.dmack_n |=> dmarq_q)
		else $error("DMA request dropped before acknowledge");
	dmarq_float_a: assert property (!selected |=> !dmarq_oe_q)
		else $error("DMA request driven while not selected");
	dmarq_rise_a: assert property (
		dma_q == DMA_IDLE && selected && dma_pending_i |=> dmarq_q)
		else $error("DMA request not raised when ready");
	ack_memory_a: assert property (mode_i == SCHP_MEMORY |=> ack_n_q)
		else $error("input acknowledge active in memory mode");
	ack_io_read_a: assert property (
		mode_i == SCHP_IO && rd_act && !p.iord_n |=> !ack_n_q)
		else $error("io read not acknowledged");
	tf_lane_a: assert property (tf_sel && rd_act |=> data_oe_q == LANE_LO)
		else $error("task file read not on low byte lane");

	sequence dma_wr_seq;
		dma_cyc && wr_act ##1 !wr_act;
	endsequence
	sequence dma_rd_seq;
		dma_cyc && rd_act;
	endsequence
	dma_write_a: assert property (
		dma_wr_seq |=> acc_q.valid && acc_q.write && acc_q.dma)
		else $error("DMA write strobe did not give a write");
	dma_read_a: assert property (
		dma_rd_seq |=> data_oe_q == LANE_BOTH)
		else $error("DMA read not driven on both lanes");

endmodule : schp_host_port

`default_nettype wire

// file: test/schp_host_model.sv
// Host adapter model that drives the card's host pins and data bus.
// Assumes the bench calls its tasks one at a time on one clock.
`default_nettype none

module schp_host_model (
	input wire logic mclk_i,
	output schp_pkg::schp_pins_t pins_o,
	output logic [15:0] data_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import schp_pkg::*;

	initial begin
		pins_o = PINS_IDLE;
		data_o = 16'h0000;
	end

	task automatic drive(input schp_pins_t p, input logic [15:0] d);
		@(posedge mclk_i);
		pins_o <= p;
		data_o <= d;
	endtask : drive

	// Strobes rise first; a released bus never keeps its last word
	task automatic release_bus();
		@(posedge mclk_i);
		pins_o <= PINS_IDLE;
		@(posedge mclk_i);
		data_o <= ~data_o;
		repeat (3) @(posedge mclk_i);
		// Step off the edge so the bench reads settled capture flops
		#1;
	endtask : release_bus

	function automatic schp_pins_t tf(input logic wr, input logic [2:0] a);
		schp_pins_t p;
		p = PINS_IDLE;
		p.cs0_n = 1'b0;
		p.iowr_n = ~wr;
		p.iord_n = wr;
		p.addr = {8'h00, a};
		return p;
	endfunction : tf

	function automatic schp_pins_t dma(input logic rd);
		schp_pins_t p;
		p = PINS_IDLE;
		p.dmack_n = 1'b0;
		p.iord_n = ~rd;
		p.iowr_n = rd;
		return p;
	endfunction : dma

endmodule : schp_host_model

`default_nettype wire

// file: test/tb_top.sv
// Self-checking bench for the storage card host port.
// Assumes the host model above and a 40 MHz clock.
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import schp_pkg::*;

	typedef struct {
		schp_mode_t m;
		schp_pins_t p;
		logic [1:0] oe;
		logic ack;
	} schp_row_t;

	logic mclk_i;
	logic srst_i;
	logic role_n;
	logic pend;
	schp_mode_t mode;
	schp_pins_t pins;
	logic [15:0] hdata;
	logic [15:0] data_o;
	schp_acc_t acc;
	schp_acc_t last_acc;
	logic [1:0] oe;
	logic ack_n;
	logic dmarq;
	logic dmarq_oe;
	logic slave;
	int bad_count;
	int n_compared;
	schp_row_t rows[7];

	schp_host_model i_schp_host_model (.mclk_i(mclk_i), .pins_o(pins),
		.data_o(hdata));

	schp_host_port i_schp_host_port (.mclk_i(mclk_i), .srst_i(srst_i),
		.mode_i(mode), .pins_i(pins), .drive_role_select_n_i(role_n),
		.data_i(hdata), .rd_data_i(16'hA55A), .dma_pending_i(pend),
		.acc_o(acc), .data_o(data_o), .data_oe_o(oe),
		.io_read_acknowledge_n_o(ack_n), .dmarq_o(dmarq),
		.dmarq_oe_o(dmarq_oe), .role_slave_o(slave));

	initial begin
		mclk_i = 1'b0;
		forever #12.5 mclk_i = ~mclk_i;
	end

	always @(posedge mclk_i) if (acc.valid === 1'b1) last_acc <= acc;

	task automatic chk(input string n, input logic [63:0] s, e);
		n_compared++;
		if (s !== e) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task automatic wrap_up();
		$display("compared %0d bad %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up

	task automatic tick(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask : tick

	task automatic wait_rq(input logic v);
		int k;
		for (k = 0; k < 20 && dmarq !== v; k++) tick(1);
		chk("dmarq wait", dmarq, v);
		if (dmarq !== v) wrap_up();
	endtask : wait_rq

	task automatic do_reset(input logic r);
		@(posedge mclk_i);
		srst_i <= 1'b1;
		role_n <= r;
		tick(10);
		chk("reset outs", {acc, data_o, oe, ack_n, dmarq, dmarq_oe},
			{33'h0, 16'h0, 2'h0, 3'h4});
		@(posedge mclk_i);
		srst_i <= 1'b0;
		tick(5);
		chk("role", slave, r);
	endtask : do_reset

	function automatic schp_pins_t mk(input logic [5:0] lo);
		schp_pins_t p;
		p = PINS_IDLE;
		{p.ce1_n, p.ce2_n, p.oe_n, p.iord_n, p.cs0_n, p.dmack_n} = ~lo;
		return p;
	endfunction : mk

	task automatic tf_wr(input logic [15:0] d);
		i_schp_host_model.drive(i_schp_host_model.tf(1'b1, 3'h6), d);
		tick(4);
		i_schp_host_model.release_bus();
	endtask : tf_wr

	initial begin
		srst_i = 1'b1;
		role_n = 1'b0;
		pend = 1'b0;
		mode = SCHP_ATA;
		bad_count = 0;
		n_compared = 0;
		rows[0] = '{SCHP_MEMORY, mk(6'h38), LANE_BOTH, 1'b1};
		rows[1] = '{SCHP_MEMORY, mk(6'h28), LANE_LO, 1'b1};
		rows[2] = '{SCHP_MEMORY, mk(6'h18), LANE_HI, 1'b1};
		rows[3] = '{SCHP_MEMORY, mk(6'h34), LANE_NONE, 1'b1};
		rows[4] = '{SCHP_IO, mk(6'h34), LANE_BOTH, 1'b0};
		rows[5] = '{SCHP_ATA, mk(6'h06), LANE_LO, 1'b1};
		rows[6] = '{SCHP_ATA, mk(6'h05), LANE_BOTH, 1'b1};
		do_reset(1'b0);
		foreach (rows[i]) begin
			@(posedge mclk_i);
			mode <= rows[i].m;
			i_schp_host_model.drive(rows[i].p, 16'h0000);
			tick(4);
			chk("lanes", oe, rows[i].oe);
			chk("ack", ack_n, rows[i].ack);
			i_schp_host_model.release_bus();
		end
		chk("read word", data_o, 16'hA55A);
		@(posedge mclk_i);
		mode <= SCHP_ATA;
		pend <= 1'b1;
		wait_rq(1'b1);
		chk("rq drive", dmarq_oe, 1'b1);
		@(posedge mclk_i);
		pend <= 1'b0;
		tick(6);
		chk("rq hold", dmarq, 1'b1);
		i_schp_host_model.drive(i_schp_host_model.dma(1'b0), 16'h1234);
		wait_rq(1'b0);
		i_schp_host_model.release_bus();
		chk("dma wr", {last_acc.write, last_acc.dma, last_acc.lanes,
			last_acc.data}, {4'hF, 16'h1234});
		@(posedge mclk_i);
		pend <= 1'b1;
		wait_rq(1'b1);
		i_schp_host_model.drive(i_schp_host_model.dma(1'b1), 16'h0000);
		tick(4);
		chk("dma rd lanes", oe, LANE_BOTH);
		@(posedge mclk_i);
		pend <= 1'b0;
		wait_rq(1'b0);
		i_schp_host_model.release_bus();
		tf_wr(16'hFF10);
		chk("tf acc", {last_acc.write, last_acc.taskfile, last_acc.lanes,
			last_acc.addr, last_acc.data[7:0]},
			{2'h3, LANE_LO, 11'h006, 8'h10});
		@(posedge mclk_i);
		pend <= 1'b1;
		tick(8);
		chk("rq other dev", dmarq_oe, 1'b0);
		do_reset(1'b1);
		tick(8);
		chk("rq master sel", dmarq_oe, 1'b0);
		@(posedge mclk_i);
		role_n <= 1'b0;
		tick(5);
		chk("role held", slave, 1'b1);
		tf_wr(16'h0010);
		wait_rq(1'b1);
		chk("rq slave drive", dmarq_oe, 1'b1);
		wrap_up();
	end

endmodule : tb_top

`default_nettype wire
